// >>> rtl/imu_timing_pkg.sv
// constants shared by the sensor readout timing block
package imu_timing_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
   localparam int CYC_PER_MS    = 1000 * CYC_PER_US;

   // mode threshold on the sample period setting
   localparam logic [7:0] NORMAL_MAX  = 8'h09;
   localparam logic [7:0] LOWPWR_MIN  = 8'h0a;
   localparam logic [7:0] PERIOD_MIN  = 8'h01;
   localparam logic [7:0] PERIOD_RST  = 8'h01;

   // functional times, as printed
   localparam int STARTUP_NORM_MS = 220;
   localparam int STARTUP_LP_MS   = 290;
   localparam int RESET_NORM_MS   = 100;
   localparam int RESET_LP_MS     = 170;
   localparam int SLEEP_NORM_MS   = 4;
   localparam int SLEEP_LP_MS     = 15;
   localparam int FLASH_NORM_MS   = 17;
   localparam int FLASH_LP_MS     = 90;
   localparam int SYNC_DELAY_US   = 600;
   localparam int SAMPLE_BASE_NS  = 1220703;

   localparam int STARTUP_NORM_CYC = STARTUP_NORM_MS * CYC_PER_MS;
   localparam int STARTUP_LP_CYC   = STARTUP_LP_MS * CYC_PER_MS;
   localparam int RESET_NORM_CYC   = RESET_NORM_MS * CYC_PER_MS;
   localparam int RESET_LP_CYC     = RESET_LP_MS * CYC_PER_MS;
   localparam int SLEEP_NORM_CYC   = SLEEP_NORM_MS * CYC_PER_MS;
   localparam int SLEEP_LP_CYC     = SLEEP_LP_MS * CYC_PER_MS;
   localparam int FLASH_NORM_CYC   = FLASH_NORM_MS * CYC_PER_MS;
   localparam int FLASH_LP_CYC     = FLASH_LP_MS * CYC_PER_MS;
   localparam int SYNC_DELAY_CYC   = SYNC_DELAY_US * CYC_PER_US;
   localparam int SAMPLE_BASE_CYC  = SAMPLE_BASE_NS / CLK_PERIOD_NS;
   localparam int DRDY_WIDTH_CYC   = 8;

   // apb register offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INTSTS = 8'h08;
   localparam logic [7:0] OFS_INTMSK = 8'h0c;
   localparam logic [7:0] OFS_SAMPLE = 8'h10;

   // control fields
   localparam int CTRL_SYNC_EN  = 8;
   localparam int CTRL_SW_RST   = 16;
   localparam int CTRL_SLEEP    = 17;
   localparam int CTRL_WAKE     = 18;
   localparam int CTRL_FLASH    = 19;

   // interrupt bits
   localparam int EV_SAMPLE = 0;
   localparam int EV_FLASH  = 1;
   localparam int EV_VALID  = 2;
   localparam int EV_W      = 3;

   // serial register indices (address bits 6:1)
   localparam logic [5:0] SPI_IDX_SAMPLE = 6'h00;
   localparam logic [5:0] SPI_IDX_STATUS = 6'h01;
   localparam logic [5:0] SPI_IDX_PERIOD = 6'h02;

   typedef enum logic [1:0] {
      ST_WAIT  = 2'b00,
      ST_RUN   = 2'b01,
      ST_FLASH = 2'b11,
      ST_SLEEP = 2'b10
   } state_t;

   typedef enum logic [1:0] {
      C_POWER = 2'b00,
      C_RESET = 2'b01,
      C_SLEEP = 2'b10
   } cause_t;
endpackage

// >>> rtl/imu_timing.sv
// sensor readout timing: mode select, recovery intervals, sampling, spi
//
// Function
// - setting at or below 0x09 is normal mode, 0x0a and above low-power
// - valid data after 220 ms at power-up; reset loads setting 0x01 (normal), so never 290 ms (low-power)
// - valid data after 100 ms or 170 ms following a reset
// - valid data after 4 ms or 15 ms when leaving sleep
// - flash test finishes after 17 ms or 90 ms
// - sample period setting 0x01..0xff, 819.2 down to about 3.21 samples/s
// - data-ready about 600 us after a sync pulse; pulses during that delay are ignored
// - each sample updates output data, then pulses data-ready while the device stays running
// - output driven on falling clock edges, input sampled on rising
// - 16-bit transfers, msb first, clock polarity 1 and phase 1
// - each 16-bit register answers on two 7-bit addresses
`timescale 1ns/1ps
`default_nettype none
module imu_timing #(
   parameter int STARTUP_NORM = imu_timing_pkg::STARTUP_NORM_CYC,
   parameter int STARTUP_LP   = imu_timing_pkg::STARTUP_LP_CYC,
   parameter int RESET_NORM   = imu_timing_pkg::RESET_NORM_CYC,
   parameter int RESET_LP     = imu_timing_pkg::RESET_LP_CYC,
   parameter int SLEEP_NORM   = imu_timing_pkg::SLEEP_NORM_CYC,
   parameter int SLEEP_LP     = imu_timing_pkg::SLEEP_LP_CYC,
   parameter int FLASH_NORM   = imu_timing_pkg::FLASH_NORM_CYC,
   parameter int FLASH_LP     = imu_timing_pkg::FLASH_LP_CYC,
   parameter int SYNC_DELAY   = imu_timing_pkg::SYNC_DELAY_CYC,
   parameter int SAMPLE_BASE  = imu_timing_pkg::SAMPLE_BASE_CYC
) (
   input  wire logic        clk,        // 100 mhz
   input  wire logic        rst,        // async, active high
   input  wire logic        psel,       // apb select
   input  wire logic        penable,    // apb access phase
   input  wire logic        pwrite,     // apb direction
   input  wire logic [7:0]  paddr,      // apb byte address
   input  wire logic [31:0] pwdata,     // apb write data
   output logic      [31:0] prdata,     // apb read data
   output logic             pready,     // apb ready
   output logic             pslverr,    // apb unmapped address
   output logic             irq,        // level interrupt
   input  wire logic        sclk,       // serial clock pin
   input  wire logic        cs_n,       // serial select pin
   input  wire logic        din,        // serial data in pin
   output logic             dout,       // serial data out pin
   output logic             dout_oe_n,  // low while dout driven
   input  wire logic        sync_clock_input, // external sample trigger
   output logic             data_ready_pin    // sample ready pulse
);
   typedef struct packed {
      imu_timing_pkg::state_t state;
      imu_timing_pkg::cause_t cause;
      logic        load;
      logic [31:0] cnt;
      logic [31:0] smp_cnt;
      logic [31:0] sync_cnt;
      logic        sync_busy;
      logic [7:0]  period;
      logic        sync_en;
      logic [15:0] sample;
      logic        valid;
      logic        pend;
      logic [3:0]  drdy_cnt;
      logic        drdy;
      logic [2:0]  sts;
      logic [2:0]  mask;
      logic        irq;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic [2:0]  sclk_s;
      logic [1:0]  cs_s;
      logic [1:0]  din_s;
      logic [2:0]  sync_s;
      logic [3:0]  bitn;
      logic [15:0] rx;
      logic [15:0] tx;
      logic        dout;
      logic        dout_oe_n;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   logic        lp;
   logic        wr;
   logic        rise;
   logic        fall;
   logic        act;
   logic        smp;
   logic [15:0] full;
   logic [15:0] word;
   logic [31:0] rdv;
   logic [2:0]  ev;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      ev    = '0;
      smp   = 1'b0;
      word  = '0;
      rdv   = '0;
      lp    = s_r.period >= imu_timing_pkg::LOWPWR_MIN;

      // pins pass two flops before use; first stage feeds only the second
      s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk};
      s_nxt.cs_s   = {s_r.cs_s[0], cs_n};
      s_nxt.din_s  = {s_r.din_s[0], din};
      s_nxt.sync_s = {s_r.sync_s[1:0], sync_clock_input};
      rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
      fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
      act  = ~s_r.cs_s[1];
      full = {s_r.rx[14:0], s_r.din_s[1]};

      // apb: one wait cycle, write and read data on the ready edge
      s_nxt.pready = psel & penable & ~s_r.pready;
      wr = psel & penable & s_r.pready & pwrite;
      unique case (paddr)
         imu_timing_pkg::OFS_CTRL:
            rdv = {23'h0, s_r.sync_en, s_r.period};
         imu_timing_pkg::OFS_STATUS:
            rdv = {16'h0, 12'h0, s_r.valid, lp, s_r.state};
         imu_timing_pkg::OFS_INTSTS: rdv = {29'h0, s_r.sts};
         imu_timing_pkg::OFS_INTMSK: rdv = {29'h0, s_r.mask};
         imu_timing_pkg::OFS_SAMPLE: rdv = {16'h0, s_r.sample};
         default: rdv = '0;
      endcase
      if (s_nxt.pready) begin
         s_nxt.prdata  = pwrite ? 32'h0 : rdv;
         s_nxt.pslverr = paddr > imu_timing_pkg::OFS_SAMPLE
                       || paddr[1:0] != 2'h0;
      end
      if (wr && paddr == imu_timing_pkg::OFS_CTRL) begin
         // zero is out of range; hold the shortest period
         s_nxt.period  = (pwdata[7:0] < imu_timing_pkg::PERIOD_MIN)
                       ? imu_timing_pkg::PERIOD_MIN : pwdata[7:0];
         s_nxt.sync_en = pwdata[imu_timing_pkg::CTRL_SYNC_EN];
      end
      if (wr && paddr == imu_timing_pkg::OFS_INTMSK)
         s_nxt.mask = pwdata[2:0];

      ////////////////////////////////////////////////////////////////////
      unique case (s_r.state)
         imu_timing_pkg::ST_WAIT: begin
            if (s_r.load) begin
               s_nxt.load = 1'b0;
               unique case (s_r.cause)
                  imu_timing_pkg::C_POWER:
                     s_nxt.cnt = 32'(lp ? STARTUP_LP : STARTUP_NORM) - 1;
                  imu_timing_pkg::C_RESET:
                     s_nxt.cnt = 32'(lp ? RESET_LP : RESET_NORM) - 1;
                  default:
                     s_nxt.cnt = 32'(lp ? SLEEP_LP : SLEEP_NORM) - 1;
               endcase
            end else if (s_r.cnt == 32'h0) begin
               s_nxt.state   = imu_timing_pkg::ST_RUN;
               s_nxt.smp_cnt = '0;
               ev[imu_timing_pkg::EV_VALID] = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 1;
            end
         end
         imu_timing_pkg::ST_RUN: begin
            if (s_r.sync_en) begin
               // sample follows a rising sync edge by a fixed delay; edges during the delay are ignored
               if (s_r.sync_s[1] & ~s_r.sync_s[2] & ~s_r.sync_busy) begin
                  s_nxt.sync_busy = 1'b1;
                  s_nxt.sync_cnt  = 32'(SYNC_DELAY) - 1;
               end else if (s_r.sync_busy) begin
                  if (s_r.sync_cnt == 32'h0) begin
                     s_nxt.sync_busy = 1'b0;
                     smp = 1'b1;
                  end else begin
                     s_nxt.sync_cnt = s_r.sync_cnt - 1;
                  end
               end
            end else if (s_r.smp_cnt == 32'h0) begin
               smp = 1'b1;
               s_nxt.smp_cnt = 32'(s_r.period) * 32'(SAMPLE_BASE) - 1;
            end else begin
               s_nxt.smp_cnt = s_r.smp_cnt - 1;
            end
            if (wr && paddr == imu_timing_pkg::OFS_CTRL) begin
               if (pwdata[imu_timing_pkg::CTRL_FLASH]) begin
                  s_nxt.state = imu_timing_pkg::ST_FLASH;
                  s_nxt.cnt   = 32'(lp ? FLASH_LP : FLASH_NORM) - 1;
               end else if (pwdata[imu_timing_pkg::CTRL_SLEEP]) begin
                  s_nxt.state = imu_timing_pkg::ST_SLEEP;
                  s_nxt.valid = 1'b0;
               end
            end
         end
         imu_timing_pkg::ST_FLASH: begin
            // no sampling while the flash test runs
            if (s_r.cnt == 32'h0) begin
               s_nxt.state = imu_timing_pkg::ST_RUN;
               ev[imu_timing_pkg::EV_FLASH] = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 1;
            end
         end
         imu_timing_pkg::ST_SLEEP: begin
            if (wr && paddr == imu_timing_pkg::OFS_CTRL
                && pwdata[imu_timing_pkg::CTRL_WAKE]) begin
               s_nxt.state = imu_timing_pkg::ST_WAIT;
               s_nxt.cause = imu_timing_pkg::C_SLEEP;
               s_nxt.load  = 1'b1;
            end
         end
      endcase
      if (wr && paddr == imu_timing_pkg::OFS_CTRL
          && pwdata[imu_timing_pkg::CTRL_SW_RST]) begin
         s_nxt.state     = imu_timing_pkg::ST_WAIT;
         s_nxt.cause     = imu_timing_pkg::C_RESET;
         s_nxt.load      = 1'b1;
         s_nxt.valid     = 1'b0;
         s_nxt.sync_busy = 1'b0;
         smp = 1'b0;
      end

      // data first, pulse one cycle later
      if (smp) begin
         s_nxt.sample = s_r.sample + 16'h1;
         s_nxt.valid  = 1'b1;
         ev[imu_timing_pkg::EV_SAMPLE] = 1'b1;
      end
      s_nxt.pend = smp;
      if (s_r.pend)
         s_nxt.drdy_cnt = 4'(imu_timing_pkg::DRDY_WIDTH_CYC - 1);
      else if (s_r.drdy_cnt != 4'h0)
         s_nxt.drdy_cnt = s_r.drdy_cnt - 4'h1;
      s_nxt.drdy = (s_r.pend || (s_r.drdy && s_r.drdy_cnt != 4'h0))
                 && s_nxt.state == imu_timing_pkg::ST_RUN
                 && s_nxt.valid;

      // set wins over a same-cycle clear
      s_nxt.sts = (s_r.sts & ~((wr && paddr == imu_timing_pkg::OFS_INTSTS)
                   ? pwdata[2:0] : 3'h0)) | ev;
      s_nxt.irq = |(s_nxt.sts & s_nxt.mask);

      ////////////////////////////////////////////////////////////////////
      // serial slave, mode 3: idle-high clock
      unique case (full[14:9])
         imu_timing_pkg::SPI_IDX_SAMPLE: word = s_r.sample;
         imu_timing_pkg::SPI_IDX_STATUS:
            word = {12'h0, s_r.valid, lp, s_r.state};
         imu_timing_pkg::SPI_IDX_PERIOD: word = {8'h0, s_r.period};
         default: word = '0;
      endcase
      s_nxt.dout_oe_n = ~act;
      if (!act) begin
         s_nxt.bitn = '0;
      end else begin
         if (fall) begin
            s_nxt.dout = s_r.tx[15];
            s_nxt.tx   = {s_r.tx[14:0], 1'b0};
         end
         if (rise) begin
            s_nxt.rx   = full;
            s_nxt.bitn = s_r.bitn + 4'h1;
            // both byte addresses of a register select the same word
            if (s_r.bitn == 4'hf)
               s_nxt.tx = word;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r        <= '0;
         s_r.state  <= imu_timing_pkg::ST_WAIT;
         s_r.cause  <= imu_timing_pkg::C_POWER;
         s_r.load   <= 1'b1;
         s_r.period <= imu_timing_pkg::PERIOD_RST;
         s_r.sclk_s <= 3'h7;
         s_r.cs_s   <= 2'h3;
         s_r.dout_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata         = s_r.prdata;
   assign pready         = s_r.pready;
   assign pslverr        = s_r.pslverr;
   assign irq            = s_r.irq;
   assign dout           = s_r.dout;
   assign dout_oe_n      = s_r.dout_oe_n;
   assign data_ready_pin = s_r.drdy;

   ////////////////////////////////////////////////////////////////////////
   a_mode_pick: assert property (@(posedge clk) disable iff (rst)
      s_r.state == imu_timing_pkg::ST_WAIT && s_r.load
      && s_r.cause == imu_timing_pkg::C_RESET
      |=> s_r.cnt == 32'(($past(s_r.period) > 8'h09)
                     ? RESET_LP : RESET_NORM) - 1)
      else $error("mode threshold wrong");
   a_boot_len: assert property (@(posedge clk) disable iff (rst)
      s_r.state == imu_timing_pkg::ST_WAIT && s_r.load
      && s_r.cause == imu_timing_pkg::C_POWER
      |=> s_r.cnt == 32'((s_r.period >= 8'h0a)
                     ? STARTUP_LP : STARTUP_NORM) - 1)
      else $error("startup interval wrong");
   a_sleep_len: assert property (@(posedge clk) disable iff (rst)
      s_r.state == imu_timing_pkg::ST_WAIT && s_r.load
      && s_r.cause == imu_timing_pkg::C_SLEEP
      |=> s_r.cnt == 32'((s_r.period >= 8'h0a)
                     ? SLEEP_LP : SLEEP_NORM) - 1)
      else $error("sleep recovery wrong");
   a_wait_exit: assert property (@(posedge clk) disable iff (rst)
      s_r.state == imu_timing_pkg::ST_WAIT && !s_r.load
      && s_r.cnt == 32'h0 && !s_nxt.load
      |=> s_r.state == imu_timing_pkg::ST_RUN && s_r.sts[2])
      else $error("recovery did not end");
   a_flash_done: assert property (@(posedge clk) disable iff (rst)
      s_r.state == imu_timing_pkg::ST_FLASH && s_r.cnt == 32'h0
      && !s_nxt.load
      |=> s_r.state == imu_timing_pkg::ST_RUN && s_r.sts[1])
      else $error("flash test end wrong");
   a_period_ok: assert property (@(posedge clk) disable iff (rst)
      s_r.period != 8'h00)
      else $error("sample period zero");
   a_sync_delay: assert property (@(posedge clk) disable iff (rst)
      s_r.sync_en && s_r.sync_busy && s_r.sync_cnt == 32'h0 && !s_nxt.load
      && s_r.state == imu_timing_pkg::ST_RUN |=> $changed(s_r.sample))
      else $error("sync delay wrong");
   a_drdy_after: assert property (@(posedge clk) disable iff (rst)
      $changed(s_r.sample) && s_r.state == imu_timing_pkg::ST_RUN
      && s_nxt.state == imu_timing_pkg::ST_RUN
      |=> data_ready_pin && $stable(s_r.sample))
      else $error("data-ready did not follow sample");
   a_drdy_quiet: assert property (@(posedge clk) disable iff (rst)
      data_ready_pin |-> s_r.valid && s_r.state == imu_timing_pkg::ST_RUN)
      else $error("data-ready before valid data");
   a_spi_edge: assert property (@(posedge clk) disable iff (rst)
      $changed(s_r.dout) |-> $past(fall) && $past(act))
      else $error("dout moved off a falling edge");
   a_spi_word: assert property (@(posedge clk) disable iff (rst)
      act && rise && s_r.bitn == 4'hf |=> s_r.bitn == 4'h0)
      else $error("transfer not 16 bits");
endmodule
`default_nettype wire

// >>> test/imu_host_model.sv
// host-side serial master model for the sensor readout block
`timescale 1ns/1ps
`default_nettype none
module imu_host_model #(
   parameter real HALF_NS = 62.5, // faster than the pin limit
   parameter real GAP_NS  = 9000.0
) (
   output logic      sclk,      // serial clock, idles high
   output logic      cs_n,      // select, active low
   output logic      din,       // data to the device
   input  wire logic dout,      // data from the device
   input  wire logic dout_oe_n  // low while the device drives
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one frame; clock stands high outside frames
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n = 1'b0;
      #100;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         din  = tx[i];
         #(HALF_NS);
         sclk = 1'b1;
         rx[i] = dout_oe_n ? 1'bx : dout;
         #(HALF_NS);
      end
      #100;
      cs_n = 1'b1;
      // released line has no pull, so show the inverse
      din = ~din;
      #(GAP_NS);
   endtask
endmodule
`default_nettype wire

// >>> test/test_imu_timing.sv
// self-checking bench for the sensor readout timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); \
   end end
module test_imu_timing;
   localparam int T_SU = 200;
   localparam int T_RS_N = 100;
   localparam int T_RS_L = 150;
   localparam int T_SL_N = 40;
   localparam int T_SL_L = 80;
   localparam int T_FL_N = 60;
   localparam int T_FL_L = 120;
   localparam int T_SYNC = 60;
   localparam int T_BASE = 20;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        sclk, cs_n, din, dout, dout_oe_n, sync, drdy, dr_seen, err;
   int          fails = 0;
   int          checked = 0;
   int          cyc = 0;
   int          t_rel;

   imu_timing #(.STARTUP_NORM(T_SU), .STARTUP_LP(T_SU + 60),
      .RESET_NORM(T_RS_N), .RESET_LP(T_RS_L), .SLEEP_NORM(T_SL_N),
      .SLEEP_LP(T_SL_L), .FLASH_NORM(T_FL_N), .FLASH_LP(T_FL_L),
      .SYNC_DELAY(T_SYNC), .SAMPLE_BASE(T_BASE)) imu_timing_i (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
      .sync_clock_input(sync), .data_ready_pin(drdy));
   imu_host_model imu_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (drdy === 1'b1) dr_seen <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) fails++;
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask
   task automatic rise(output int t);
      int n;
      n = 0;
      while (drdy === 1'b1) @(posedge clk);
      while (drdy !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      t = cyc;
   endtask
   // command, then no data-ready and no run before the interval ends
   task automatic recover(input logic [31:0] cmd, input int exp,
                          input logic chk_dr);
      int t0;
      logic [31:0] s;
      t0 = cyc;
      if (cmd !== 32'h0) wr(imu_timing_pkg::OFS_CTRL, cmd);
      else t0 = t_rel;
      repeat (10) @(posedge clk);
      dr_seen = 1'b0;
      while (cyc < t0 + exp - 8) @(posedge clk);
      rd(imu_timing_pkg::OFS_STATUS, s);
      `CHK(s[1:0] == 2'b01, 1'b0)
      if (chk_dr) `CHK(dr_seen, 1'b0)
      do rd(imu_timing_pkg::OFS_STATUS, s);
      while (s[1:0] !== 2'b01 && cyc < t0 + exp + 40);
      `CHK(cyc - t0 <= exp + 12, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic regs;
      logic [31:0] r;
      rd(imu_timing_pkg::OFS_CTRL, r);
      `CHK(r, 32'h00000001)
      rd(imu_timing_pkg::OFS_INTMSK, r);
      `CHK(r, 32'h00000000)
      rd(8'h14, r);
      `CHK(err, 1'b1)
      `CHK(r, 32'h00000000)
      wr(imu_timing_pkg::OFS_CTRL, 32'h0);
      rd(imu_timing_pkg::OFS_CTRL, r);
      `CHK(r[7:0], 8'h01)
      wr(imu_timing_pkg::OFS_CTRL, 32'hff);
      rd(imu_timing_pkg::OFS_CTRL, r);
      `CHK(r[7:0], 8'hff)
   endtask
   task automatic modes;
      logic [7:0]  pm [2] = '{8'h09, 8'h0a};
      int          rs [2] = '{T_RS_N, T_RS_L};
      int          sl [2] = '{T_SL_N, T_SL_L};
      int          fl [2] = '{T_FL_N, T_FL_L};
      logic [31:0] r;
      for (int m = 0; m < 2; m++) begin
         wr(imu_timing_pkg::OFS_CTRL, {24'h0, pm[m]});
         rd(imu_timing_pkg::OFS_STATUS, r);
         `CHK(r[2], m[0])
         recover({12'h0, 4'h1, 8'h0, pm[m]}, rs[m], 1'b1);
         wr(imu_timing_pkg::OFS_CTRL, {12'h0, 4'h2, 8'h0, pm[m]});
         rd(imu_timing_pkg::OFS_STATUS, r);
         `CHK(r[1:0], 2'b10)
         recover({12'h0, 4'h4, 8'h0, pm[m]}, sl[m], 1'b1);
         wr(imu_timing_pkg::OFS_INTSTS, 32'h7);
         recover({12'h0, 4'h8, 8'h0, pm[m]}, fl[m], 1'b0);
         rd(imu_timing_pkg::OFS_INTSTS, r);
         `CHK(r[1], 1'b1)
      end
   endtask
   task automatic samples;
      int          t1, t2;
      logic [31:0] s1, s2;
      for (int p = 1; p <= 3; p += 2) begin
         wr(imu_timing_pkg::OFS_CTRL, p);
         wr(imu_timing_pkg::OFS_INTMSK, 32'h1);
         wr(imu_timing_pkg::OFS_INTSTS, 32'h7);
         rise(t1);
         rd(imu_timing_pkg::OFS_SAMPLE, s1);
         rise(t2);
         rd(imu_timing_pkg::OFS_SAMPLE, s2);
         `CHK(t2 - t1, p * T_BASE)
         `CHK(s2[15:0], s1[15:0] + 16'h1)
         `CHK(irq, 1'b1)
         wr(imu_timing_pkg::OFS_INTMSK, 32'h0);
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b0)
      end
   endtask
   task automatic sync_test;
      int t0, t;
      wr(imu_timing_pkg::OFS_CTRL, 32'h101);
      repeat (100) @(posedge clk);
      sync <= 1'b1;
      t0 = cyc;
      rise(t);
      `CHK(t - t0 >= T_SYNC && t - t0 <= T_SYNC + 6, 1'b1)
      while (cyc < t0 + 500) @(posedge clk);
      sync <= 1'b0;
      wr(imu_timing_pkg::OFS_CTRL, 32'h1);
   endtask
   task automatic spi_test;
      logic [15:0] rx;
      wr(imu_timing_pkg::OFS_CTRL, 32'h5);
      imu_host_model_i.xfer(16'h0400, rx);
      imu_host_model_i.xfer(16'h0500, rx);
      `CHK(rx, 16'h0005)
      imu_host_model_i.xfer(16'h0000, rx);
      `CHK(rx, 16'h0005)
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sync = 1'b0;
      dr_seen = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_rel = cyc;
      recover(32'h0, T_SU, 1'b1);
      regs();
      modes();
      samples();
      sync_test();
      spi_test();
      summarize();
   end
   // whole run is a few thousand cycles; this cuts a hang short
   initial begin
      #200000;
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
